//--- inc/adcp_pkg.sv
// ****************************************************************
// Readout port constants
// ****************************************************************
package adcp_pkg;

    // Core clock period and conversion time, both in nanoseconds
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONV_TIME_NS  = 500;
    // Conversion length in core cycles, rounded up, at least one
    localparam int CONV_CYCLES_RAW =
        (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;

    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CONV_CNT_LAST = CNT_W'(CONV_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO      = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE       = 8'h01;

    // Result word and output frame
    localparam int RESULT_BITS = 16;
    localparam int FRAME_BITS  = 17;
    localparam int FIFO_DEPTH  = 16;
    localparam logic [4:0] BITS_NO_BUSY = 5'h10;
    localparam logic [4:0] BITS_BUSY    = 5'h11;
    localparam logic [4:0] BITS_LAST    = 5'h01;
    localparam logic [4:0] BITS_NONE    = 5'h00;

    // Start bit levels: select mode drives low, chain drives high
    localparam logic START_SELECT = 1'b0;
    localparam logic START_CHAIN  = 1'b1;

    // Synchroniser reset value
    localparam logic [2:0] SYNC_RESET = 3'h0;

    // Port sequencer states
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_CONV  = 5'h02,
        ST_FETCH = 5'h04,
        ST_HOLD  = 5'h08,
        ST_SHIFT = 5'h10
    } adcp_state_type;

endpackage

//--- logic/adcp_port.sv
`timescale 1ns/1ns
// Functional notes
// - Convert-start rise: data-in high selects select mode
// - Select mode start: conversion begins, output floats
// - Started conversion always completes
// - Conversion end: acquisition phase, converter powered down
// - 3-wire no-busy: start fall shows MSB
// - Output bit changes only on clock falls
// - 3-wire no-busy: float after 16th fall
// - Select-mode busy: float, then drive low, then data
// - 3-wire busy: float after 17th fall
// - Data-in and start both low: drive low
// - 4-wire: data-in fall shows MSB, then shifts
// - 4-wire no-busy: float at 16th fall/data-in rise
// - 4-wire busy: float at 17th fall/data-in rise
// - Chain mode: clock level selects busy option
// - Chain no-busy: MSB appears at conversion end
// - Chain: data-in shifts in on clock falls
// - Chain busy: drive high when ready

// ****************************************************************
// Result FIFO
// ****************************************************************
module adcp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,        // Core clock
    input  wire logic             rstn,       // Async reset, low
    input  wire logic [WIDTH-1:0] in_data,    // Write word
    input  wire logic             in_valid,   // Write offered
    output logic                  in_ready,   // Room for a word
    output logic      [WIDTH-1:0] out_data,   // Head word
    output logic                  out_valid,  // Head word present
    input  wire logic             out_ready   // Head word taken
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             push;
    logic             pop;

    // Handshakes and next fill level
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data  = mem_q[rd_q];
    assign out_valid = (cnt_q != '0);

    // Storage array
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers, level and registered ready
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_q     <= '0;
            rd_q     <= '0;
            cnt_q    <= '0;
            in_ready <= 1'b0;
        end
        else
        begin
            wr_q     <= push ? AW'(wr_q + 1'b1) : wr_q;
            rd_q     <= pop ? AW'(rd_q + 1'b1) : rd_q;
            cnt_q    <= cnt_d;
            in_ready <= (cnt_d < (AW+1)'(DEPTH));
        end
    end
endmodule // adcp_fifo

// ****************************************************************
// Serial readout port
// ****************************************************************
module adcp_port (
    input  wire logic        core_clk,          // Core clock, 20 MHz
    input  wire logic        rstn,              // Async reset, low
    input  wire logic        convert_start,     // Convert start pin
    input  wire logic        serial_data_in,    // Serial data in pin
    input  wire logic        serial_clock_pin,  // Serial clock pin
    output logic             serial_data_out,   // Serial data out level
    output logic             serial_data_oe_n,  // Output enable, low
    input  wire logic [15:0] result_data,       // Converter result
    input  wire logic        result_valid,      // Result offered
    output logic             result_ready,      // FIFO has room
    output logic             sample_strobe,     // Sample pulse
    output logic             converter_active   // Converter powered
);
    adcp_pkg::adcp_state_type state_q;

    logic [2:0]  cnv_s_q;
    logic [2:0]  sdi_s_q;
    logic [2:0]  sck_s_q;
    logic        cnv_q;
    logic        sdi_q;
    logic        sck_q;
    logic        cnv_d;
    logic        sdi_d;
    logic        sck_d;
    logic        cnv_rise;
    logic        cnv_fall;
    logic        sdi_rise;
    logic        sck_fall;
    logic        sel_low;
    logic        mode_cs_q;
    logic        busy_chain_q;
    logic        busy_q;
    logic [adcp_pkg::CNT_W-1:0]       cnt_q;
    logic [adcp_pkg::FRAME_BITS-1:0]  frame_q;
    logic [4:0]  bits_q;
    logic [15:0] head_data;
    logic        head_valid;
    logic        pop;
    logic        drive;
    logic        level;

    // Filtered level: moves once second and third stages agree
    function automatic logic filt(input logic [2:0] s, input logic lvl);
        filt = (s[1] == s[2]) ? s[2] : lvl;
    endfunction

    // ************************************************************
    // Pin synchronisers and edge detection
    // ************************************************************

    // Three-stage shift of each pin
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnv_s_q <= adcp_pkg::SYNC_RESET;
            sdi_s_q <= adcp_pkg::SYNC_RESET;
            sck_s_q <= adcp_pkg::SYNC_RESET;
        end
        else
        begin
            cnv_s_q <= {cnv_s_q[1:0], convert_start};
            sdi_s_q <= {sdi_s_q[1:0], serial_data_in};
            sck_s_q <= {sck_s_q[1:0], serial_clock_pin};
        end
    end

    assign cnv_d = filt(cnv_s_q, cnv_q);
    assign sdi_d = filt(sdi_s_q, sdi_q);
    assign sck_d = filt(sck_s_q, sck_q);

    // Accepted pin levels
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnv_q <= 1'b0;
            sdi_q <= 1'b0;
            sck_q <= 1'b0;
        end
        else
        begin
            cnv_q <= cnv_d;
            sdi_q <= sdi_d;
            sck_q <= sck_d;
        end
    end

    // Edge events and select level
    assign cnv_rise = cnv_d && !cnv_q;
    assign cnv_fall = !cnv_d && cnv_q;
    assign sdi_rise = sdi_d && !sdi_q;
    assign sck_fall = !sck_d && sck_q;
    assign sel_low  = !(cnv_q && sdi_q);

    // ************************************************************
    // Result buffer
    // ************************************************************

    // Result pop only when a conversion has ended
    assign pop = (state_q == adcp_pkg::ST_FETCH) && head_valid;

    adcp_fifo #(
        .WIDTH (adcp_pkg::RESULT_BITS),
        .DEPTH (adcp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (core_clk),
        .rstn      (rstn),
        .in_data   (result_data),
        .in_valid  (result_valid),
        .in_ready  (result_ready),
        .out_data  (head_data),
        .out_valid (head_valid),
        .out_ready (pop)
    );

    // ************************************************************
    // Port sequencer
    // ************************************************************

    // Mode capture, conversion timing, framing and shifting
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q      <= adcp_pkg::ST_IDLE;
            mode_cs_q    <= 1'b0;
            busy_chain_q <= 1'b0;
            busy_q       <= 1'b0;
            cnt_q        <= adcp_pkg::CNT_ZERO;
            frame_q      <= '0;
            bits_q       <= adcp_pkg::BITS_NONE;
        end
        else
        begin
            case (state_q)
                adcp_pkg::ST_CONV:
                begin
                    // Runs out whatever the pins do
                    cnt_q <= cnt_q + adcp_pkg::CNT_ONE;
                    if (cnt_q == adcp_pkg::CONV_CNT_LAST)
                    begin
                        state_q <= adcp_pkg::ST_FETCH;
                    end
                end
                adcp_pkg::ST_FETCH:
                begin
                    if (head_valid)
                    begin
                        if (mode_cs_q && sel_low)
                        begin
                            // Start bit low ahead of the data
                            busy_q  <= 1'b1;
                            frame_q <= {adcp_pkg::START_SELECT, head_data};
                            bits_q  <= adcp_pkg::BITS_BUSY;
                            state_q <= adcp_pkg::ST_SHIFT;
                        end
                        else if (mode_cs_q)
                        begin
                            // Wait floating for the select fall
                            busy_q  <= 1'b0;
                            frame_q <= {head_data, 1'b0};
                            bits_q  <= adcp_pkg::BITS_NO_BUSY;
                            state_q <= adcp_pkg::ST_HOLD;
                        end
                        else if (busy_chain_q)
                        begin
                            // Ready flag high, then data
                            busy_q  <= 1'b1;
                            frame_q <= {adcp_pkg::START_CHAIN, head_data};
                            bits_q  <= adcp_pkg::BITS_BUSY;
                            state_q <= adcp_pkg::ST_SHIFT;
                        end
                        else
                        begin
                            // MSB straight out at conversion end
                            busy_q  <= 1'b0;
                            frame_q <= {head_data, 1'b0};
                            bits_q  <= adcp_pkg::BITS_NO_BUSY;
                            state_q <= adcp_pkg::ST_SHIFT;
                        end
                    end
                end
                adcp_pkg::ST_HOLD,
                adcp_pkg::ST_SHIFT,
                adcp_pkg::ST_IDLE:
                begin
                    if (cnv_rise)
                    begin
                        // Mode and chain busy option latched here
                        mode_cs_q    <= sdi_q;
                        busy_chain_q <= sck_q;
                        cnt_q        <= adcp_pkg::CNT_ZERO;
                        state_q      <= adcp_pkg::ST_CONV;
                    end
                    else if (state_q == adcp_pkg::ST_HOLD)
                    begin
                        if (sel_low)
                        begin
                            state_q <= adcp_pkg::ST_SHIFT;
                        end
                    end
                    else if (state_q == adcp_pkg::ST_SHIFT)
                    begin
                        if (mode_cs_q && sdi_rise)
                        begin
                            state_q <= adcp_pkg::ST_IDLE;
                        end
                        else if (!mode_cs_q && cnv_fall)
                        begin
                            state_q <= adcp_pkg::ST_IDLE;
                        end
                        else if (sck_fall)
                        begin
                            // Next bit only on a clock fall
                            // Without a start bit the pad stays at bit 0
                            frame_q <= busy_q
                                ? {frame_q[15:0], !mode_cs_q && sdi_q}
                                : {frame_q[15:1], !mode_cs_q && sdi_q,
                                   1'b0};
                            if (bits_q != adcp_pkg::BITS_NONE)
                            begin
                                bits_q <= bits_q - adcp_pkg::BITS_LAST;
                            end
                            if (mode_cs_q && bits_q == adcp_pkg::BITS_LAST)
                            begin
                                state_q <= adcp_pkg::ST_IDLE;
                            end
                        end
                    end
                end
                default:
                begin
                    state_q <= adcp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Pin drivers and converter status
    // ************************************************************

    // Output decision from the sequencer state
    always_comb
    begin
        drive = 1'b0;
        level = 1'b0;
        case (state_q)
            adcp_pkg::ST_SHIFT:
            begin
                drive = 1'b1;
                level = frame_q[adcp_pkg::FRAME_BITS-1];
            end
            adcp_pkg::ST_IDLE:
            begin
                drive = !cnv_q && !sdi_q;
            end
            default:
            begin
                drive = 1'b0;
            end
        endcase
    end

    // Registered pin outputs and converter status
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            serial_data_out  <= 1'b0;
            serial_data_oe_n <= 1'b1;
            sample_strobe    <= 1'b0;
            converter_active <= 1'b0;
        end
        else
        begin
            serial_data_out  <= level;
            serial_data_oe_n <= !drive;
            sample_strobe    <= cnv_rise && (state_q != adcp_pkg::ST_CONV)
                                && (state_q != adcp_pkg::ST_FETCH);
            converter_active <= (state_q == adcp_pkg::ST_CONV);
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    mode_latch_a: assert property (
        state_q == adcp_pkg::ST_IDLE && cnv_rise
        |=> mode_cs_q == $past(sdi_q) && state_q == adcp_pkg::ST_CONV)
        else $error("mode not latched at convert start");
    conv_float_a: assert property (
        state_q == adcp_pkg::ST_CONV |=> serial_data_oe_n)
        else $error("output driven during conversion");
    conv_runs_a: assert property (
        state_q == adcp_pkg::ST_CONV && cnt_q != adcp_pkg::CONV_CNT_LAST
        |=> state_q == adcp_pkg::ST_CONV)
        else $error("conversion cut short");
    power_down_a: assert property (
        state_q == adcp_pkg::ST_CONV ##1 state_q == adcp_pkg::ST_FETCH
        |=> !converter_active)
        else $error("converter not powered down");
    msb_show_a: assert property (
        state_q == adcp_pkg::ST_HOLD && sel_low && !cnv_rise
        |=> ##1 !serial_data_oe_n && serial_data_out == $past(frame_q[16], 2))
        else $error("MSB not shown on select fall");
    bit_stable_a: assert property (
        state_q == adcp_pkg::ST_SHIFT && !sck_fall |=> $stable(frame_q))
        else $error("output bit moved off a clock fall");
    count_end_a: assert property (
        state_q == adcp_pkg::ST_SHIFT && mode_cs_q && !cnv_rise && !sdi_rise
        && sck_fall && bits_q == adcp_pkg::BITS_LAST
        |=> state_q == adcp_pkg::ST_IDLE
        ##1 (serial_data_oe_n || $past(!cnv_q && !sdi_q)))
        else $error("no float after last bit");
    busy_low_a: assert property (
        pop && mode_cs_q && sel_low
        |=> !frame_q[16] && bits_q == adcp_pkg::BITS_BUSY)
        else $error("busy start bit wrong");
    deselect_a: assert property (
        state_q == adcp_pkg::ST_SHIFT && mode_cs_q && sdi_rise && !cnv_rise
        |=> state_q == adcp_pkg::ST_IDLE)
        else $error("no float on data-in rise");
    idle_low_a: assert property (
        state_q == adcp_pkg::ST_IDLE && !cnv_q && !sdi_q
        |=> !serial_data_oe_n && !serial_data_out)
        else $error("output not driven low");
    chain_opt_a: assert property (
        state_q == adcp_pkg::ST_IDLE && cnv_rise
        |=> busy_chain_q == $past(sck_q))
        else $error("chain busy option not latched");
    chain_shift_a: assert property (
        state_q == adcp_pkg::ST_SHIFT && !mode_cs_q && sck_fall && !cnv_fall
        && !cnv_rise
        |=> (busy_q ? frame_q[0] : frame_q[1]) == $past(sdi_q))
        else $error("chain data-in not shifted in");
    chain_ready_a: assert property (
        pop && !mode_cs_q && busy_chain_q |=> ##1 serial_data_out)
        else $error("chain ready flag not high");

    cover_select_c: cover property (
        state_q == adcp_pkg::ST_HOLD ##1 state_q == adcp_pkg::ST_SHIFT);
    cover_busy_c: cover property (pop && mode_cs_q && sel_low);
    cover_chain_c: cover property (pop && !mode_cs_q);
endmodule // adcp_port

//--- verif/adcp_host_model.sv
`timescale 1ns/1ns
// ****************************************************************
// Host controller model
// ****************************************************************
module adcp_host_model (
    input  wire logic core_clk,         // Core clock
    input  wire logic sdo_level,        // Resolved data-out wire
    output logic      convert_start,    // Convert start pin
    output logic      serial_data_in,   // Serial data in pin
    output logic      serial_clock_pin  // Serial clock pin
);
    // Pins low at time zero
    initial
    begin
        convert_start    = 1'b0;
        serial_data_in   = 1'b0;
        serial_clock_pin = 1'b0;
    end

    // Move all three pins just after a clock edge
    task automatic pins(input logic c, d, k);
        @(posedge core_clk);
        convert_start    <= c;
        serial_data_in   <= d;
        serial_clock_pin <= k;
    endtask

    // Clock n bits out, feeding an upstream word when asked
    task automatic frame(input int n, input logic feed,
                         input logic [15:0] up, output logic [31:0] v);
        v = 32'h0000_0000;
        @(posedge core_clk);
        serial_clock_pin <= 1'b1;
        if (feed)
            serial_data_in <= up[15];
        repeat (4) @(posedge core_clk);
        for (int i = 0; i < n; i++)
        begin
            @(negedge core_clk);
            v = {v[30:0], sdo_level};
            @(posedge core_clk);
            serial_clock_pin <= 1'b0;
            repeat (4) @(posedge core_clk);
            serial_clock_pin <= 1'b1;
            if (feed && i < 15)
                serial_data_in <= up[14 - i];
            repeat (3) @(posedge core_clk);
        end
    endtask
endmodule // adcp_host_model

//--- verif/test_adcp_port.sv
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
// ****************************************************************
// Readout port testbench
// ****************************************************************
module test_adcp_port;
    logic        core_clk = 1'b0;       // Core clock
    logic        rstn;                  // Reset, low
    logic        convert_start;         // Host pins
    logic        serial_data_in;
    logic        serial_clock_pin;
    logic        serial_data_out;       // Port outputs
    logic        serial_data_oe_n;
    logic [15:0] result_data;           // Result source
    logic        result_valid;
    logic        result_ready;
    logic        sample_strobe;
    logic        converter_active;
    logic        sdo_level;             // Wire with pull-up
    logic [15:0] exp_q[$];              // Words in the FIFO
    logic [15:0] w;                     // Word now read
    logic [31:0] v;                     // Captured frame
    logic [31:0] seed = 32'h8A1EB608;   // Random state
    int          fail_count = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    // Released wire floats high through its pull-up
    assign sdo_level = serial_data_oe_n ? 1'b1 : serial_data_out;

    // Design and host
    adcp_port i_adcp_port (
        .core_clk(core_clk), .rstn(rstn), .convert_start(convert_start),
        .serial_data_in(serial_data_in),
        .serial_clock_pin(serial_clock_pin),
        .serial_data_out(serial_data_out),
        .serial_data_oe_n(serial_data_oe_n), .result_data(result_data),
        .result_valid(result_valid), .result_ready(result_ready),
        .sample_strobe(sample_strobe),
        .converter_active(converter_active));
    adcp_host_model i_adcp_host_model (
        .core_clk(core_clk), .sdo_level(sdo_level),
        .convert_start(convert_start), .serial_data_in(serial_data_in),
        .serial_clock_pin(serial_clock_pin));

    // Clock, 50 ns period
    always #25 core_clk = ~core_clk;

    // Next random value
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Counts and verdict
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 12000)
        begin
            fail_count++;
            report_and_stop();
        end
    end

    // One conversion, with optional pin moves while it runs
    task automatic convert(input logic d0, k0, gl, dc, dd);
        int m;
        m = 0;
        i_adcp_host_model.pins(1'b0, d0, k0);
        repeat (6) @(posedge core_clk);
        i_adcp_host_model.pins(1'b1, d0, k0);
        while (sample_strobe !== 1'b1 && m < 20)
        begin
            @(negedge core_clk);
            m++;
        end
        `CHK(sample_strobe, 1'b1)
        @(negedge core_clk);
        `CHK(sample_strobe, 1'b0)
        `CHK(converter_active, 1'b1)
        m = 0;
        while (converter_active === 1'b1 && m < 40)
        begin
            if (d0)
                `CHK(serial_data_oe_n, 1'b1)
            @(negedge core_clk);
            m++;
            if (gl && (m == 1 || m == 3))
                i_adcp_host_model.pins(m == 3, d0, k0);
            if (dc && m == 3)
                i_adcp_host_model.pins(1'b0, d0, k0);
            if (dd && m == 3)
                i_adcp_host_model.pins(1'b1, 1'b0, k0);
        end
        `CHK(m, adcp_pkg::CONV_CYCLES)
        w = exp_q.pop_front();
        repeat (4) @(negedge core_clk);
    endtask

    // 3-wire read without start bit, nb bits long
    task automatic sel3(input int nb, input logic gl);
        convert(1'b1, 1'b0, gl, 1'b0, 1'b0);
        `CHK(serial_data_oe_n, 1'b1)
        i_adcp_host_model.pins(1'b0, 1'b1, 1'b0);
        repeat (6) @(posedge core_clk);
        i_adcp_host_model.frame(nb, 1'b0, 16'h0000, v);
        @(negedge core_clk);
        `CHK(v[15:0], w >> (16 - nb))
        if (nb == 16)
            `CHK(serial_data_oe_n, 1'b1)
    endtask

    // Main sequence
    initial
    begin
        rstn         = 1'b0;
        result_valid = 1'b0;
        result_data  = 16'h0000;
        repeat (8) @(posedge core_clk);
        `CHK(serial_data_oe_n, 1'b1)
        `CHK(result_ready, 1'b0)
        rstn <= 1'b1;
        for (int i = 0; i < 24; i++)
        begin
            @(posedge core_clk);
            if (result_valid && result_ready)
                exp_q.push_back(result_data);
            seed = lfsr(seed);
            result_valid <= (i < 23);
            result_data  <= seed[15:0];
        end
        @(negedge core_clk);
        `CHK(exp_q.size(), 16)
        `CHK(result_ready, 1'b0)
        `CHK(serial_data_oe_n, 1'b0)
        `CHK(serial_data_out, 1'b0)
        $display("fill done");
        sel3(16, 1'b1);
        convert(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        i_adcp_host_model.frame(17, 1'b0, 16'h0000, v);
        @(negedge core_clk);
        `CHK(v[16:0], {1'b0, w})
        `CHK(serial_data_oe_n, 1'b1)
        $display("3-wire done");
        convert(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        `CHK(serial_data_oe_n, 1'b1)
        i_adcp_host_model.pins(1'b1, 1'b0, 1'b0);
        repeat (6) @(posedge core_clk);
        i_adcp_host_model.frame(8, 1'b0, 16'h0000, v);
        i_adcp_host_model.pins(1'b1, 1'b1, 1'b1);
        repeat (6) @(negedge core_clk);
        `CHK(v[7:0], w[15:8])
        `CHK(serial_data_oe_n, 1'b1)
        convert(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        i_adcp_host_model.frame(17, 1'b0, 16'h0000, v);
        @(negedge core_clk);
        `CHK(v[16:0], {1'b0, w})
        `CHK(serial_data_oe_n, 1'b1)
        $display("4-wire done");
        convert(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        seed = lfsr(seed);
        i_adcp_host_model.frame(32, 1'b1, seed[31:16], v);
        `CHK(v, {w, seed[31:16]})
        i_adcp_host_model.pins(1'b0, 1'b0, 1'b0);
        repeat (6) @(negedge core_clk);
        `CHK(serial_data_oe_n, 1'b0)
        convert(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        i_adcp_host_model.frame(17, 1'b0, 16'h0000, v);
        `CHK(v[16:0], {1'b1, w})
        i_adcp_host_model.pins(1'b0, 1'b0, 1'b0);
        $display("chain done");
        sel3(5, 1'b0);
        while (exp_q.size() > 0)
        begin
            seed = lfsr(seed);
            repeat (seed[3:0]) @(posedge core_clk);
            sel3(16, 1'b0);
        end
        `CHK(result_ready, 1'b1)
        $display("drain done");
        report_and_stop();
    end
endmodule // test_adcp_port
